// File: hw/fgcc_config_control.sv
// fgcc_config_control: control registers and derived control of the gauge
module fgcc_config_control #(
  parameter logic [32:0] SLEEP_CYC = 33'(fgcc_pkg::SLEEP_TIMEOUT_CYC),
  parameter logic [31:0] TASK_CYC  = 32'(fgcc_pkg::TASK_PERIOD_CYC)
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pins, asynchronous
  input  wire logic        temperature_sense_pin,
  input  wire logic        sda_in,
  input  wire logic        scl_in,
  // gauging core events and levels, same clock
  input  wire logic [3:0]  thresh_exceeded,
  input  wire logic        charge_step_event,
  input  wire logic        model_load_done,
  input  wire logic [15:0] die_temperature,
  input  wire logic [15:0] thermistor_temperature,
  input  wire logic [15:0] host_temperature,
  input  wire logic [15:0] average_current,
  input  wire logic [15:0] average_cell_voltage,
  input  wire logic [15:0] empty_voltage_setting,
  // control outputs
  output logic             alert_output_pin,
  output logic             shutdown_active,
  output logic             temperature_source_select,
  output logic             temp_measure_enable,
  output logic             thermistor_bias_on,
  output logic [15:0]      temperature_in_use,
  output logic             hypothetical_rate_enable,
  output logic             peak_power_calc_enable,
  output logic             model_load_trigger,
  output logic [31:0]      power_average_timeconst,
  output logic [7:0]       deep_relax_window,
  output logic [15:0]      estimate_current
);

  // ------------------------------------------------------------
  // decode and storage
  // ------------------------------------------------------------
  function automatic logic [2:0] fgcc_decode(input logic [11:0] a);
    fgcc_decode = {a == fgcc_pkg::STAT_ADDR, a == fgcc_pkg::SEC_ADDR,
                   a == fgcc_pkg::PRI_ADDR};
  endfunction : fgcc_decode

  logic [15:0]             pri;
  logic [15:0]             sec;
  logic [15:0]             pri_act;
  logic [15:0]             sec_act;
  logic [6:0]              stat;
  logic [6:0]              next_stat;
  logic [2:0]              hit;
  logic                    wr;
  logic                    wr_pri;
  logic                    wr_sec;
  logic                    wr_stat;
  logic                    task_tick;
  logic                    wake_now;
  logic                    sleep_now;
  fgcc_pkg::fgcc_power_t   pstate;
  logic [32:0]             sleep_cnt;
  logic [2:0]              th_sync;
  logic [2:0]              sda_sync;
  logic [2:0]              scl_sync;

  assign hit     = fgcc_decode(paddr);
  assign wr      = psel & penable & pwrite;
  assign wr_pri  = wr & hit[0];
  assign wr_sec  = wr & hit[1];
  assign wr_stat = wr & hit[2];
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~|hit;

  fgcc_task_timer #(
    .TASK_CYC (TASK_CYC)
  ) u_task (
    .pclk      (pclk),
    .presetn   (presetn),
    .task_tick (task_tick)
  );

  // read data captured in the setup phase so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= 32'h00000000;
      case (hit)
        3'b001:  prdata[15:0] <= pri;
        3'b010:  prdata[15:0] <= sec;
        3'b100:  prdata[8:0]  <= {pstate == fgcc_pkg::FGCC_SHUTDOWN,
                                  1'b0, stat};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // host write wins over the forced sleep clear on wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri <= fgcc_pkg::PRI_RESET;
    end else if (wr_pri) begin
      pri <= pwdata[15:0];
    end else if (wake_now) begin
      pri[fgcc_pkg::FORCED_SLEEP_BIT] <= 1'b0;
    end
  end

  // a host set in the completion cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec <= fgcc_pkg::SEC_RESET;
    end else if (wr_sec) begin
      sec <= pwdata[15:0];
    end else if (model_load_done) begin
      sec[fgcc_pkg::MODEL_LOAD_BIT] <= 1'b0;
    end
  end

  // logic acts on copies refreshed once per task period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_act <= fgcc_pkg::PRI_RESET;
      sec_act <= fgcc_pkg::SEC_RESET;
    end else if (task_tick) begin
      pri_act <= pri;
      sec_act <= sec;
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      th_sync  <= 3'h0;
      sda_sync <= 3'h7;
      scl_sync <= 3'h7;
    end else begin
      th_sync  <= {th_sync[1:0], temperature_sense_pin};
      sda_sync <= {sda_sync[1:0], sda_in};
      scl_sync <= {scl_sync[1:0], scl_in};
    end
  end

  logic th_fall;
  logic th_rise;
  logic sda_edge;
  logic bus_rise;
  assign th_fall  = th_sync[2] & ~th_sync[1];
  assign th_rise  = ~th_sync[2] & th_sync[1];
  assign sda_edge = sda_sync[2] ^ sda_sync[1];
  assign bus_rise = (~sda_sync[2] & sda_sync[1]) | (~scl_sync[2] & scl_sync[1]);

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  logic [3:0] latch_cls;
  assign latch_cls = {pri_act[fgcc_pkg::CURR_LATCH_BIT],
                      pri_act[fgcc_pkg::VOLT_LATCH_BIT],
                      pri_act[fgcc_pkg::TEMP_LATCH_BIT],
                      pri_act[fgcc_pkg::SOC_LATCH_BIT]};

  // a flag that is set in the clear cycle stays set
  always_comb begin
    next_stat = stat;
    for (int i = 0; i < 4; i++) begin
      if (latch_cls[i]) begin
        next_stat[i] = thresh_exceeded[i] |
                       (stat[i] & ~(wr_stat & pwdata[i]));
      end else begin
        next_stat[i] = thresh_exceeded[i];
      end
    end
    for (int j = 4; j < 7; j++) begin
      next_stat[j] = stat[j] & ~(wr_stat & pwdata[j]);
    end
    if (th_fall) begin
      next_stat[fgcc_pkg::ST_INSERT_BIT] = 1'b1;
    end
    if (th_rise) begin
      next_stat[fgcc_pkg::ST_REMOVE_BIT] = 1'b1;
    end
    if (charge_step_event) begin
      next_stat[fgcc_pkg::ST_STEP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= fgcc_pkg::STAT_RESET;
    end else begin
      stat <= next_stat;
    end
  end

  // ------------------------------------------------------------
  // alert pin
  // ------------------------------------------------------------
  logic thresh_any;
  logic next_alert;
  // temperature flag keeps updating but only reaches the pin when permitted
  assign thresh_any = stat[0] | stat[2] | stat[3] |
                      (stat[1] & sec_act[fgcc_pkg::TEMP_ALERT_EN_BIT]);
  assign next_alert =
    (pri_act[fgcc_pkg::THRESH_ALERT_BIT] & thresh_any) |
    (pri_act[fgcc_pkg::INSERT_ALERT_BIT] & stat[fgcc_pkg::ST_INSERT_BIT]) |
    (pri_act[fgcc_pkg::REMOVE_ALERT_BIT] & stat[fgcc_pkg::ST_REMOVE_BIT]) |
    (sec_act[fgcc_pkg::STEP_ALERT_EN_BIT] & stat[fgcc_pkg::ST_STEP_BIT]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_output_pin <= 1'b0;
    end else begin
      alert_output_pin <= next_alert;
    end
  end

  // ------------------------------------------------------------
  // shutdown and wake
  // ------------------------------------------------------------
  logic pin_sd;
  logic bus_sd;
  logic idle_cond;
  assign pin_sd = pri_act[fgcc_pkg::PIN_SHUTDOWN_BIT];
  assign bus_sd = pri_act[fgcc_pkg::BUS_IDLE_FORCED_SLEEP_BIT];
  // forced sleep is taken straight from the register so the wake clear holds
  assign idle_cond = (pin_sd & th_sync[1]) |
                     (bus_sd & ~sda_sync[1] & ~scl_sync[1]) |
                     pri[fgcc_pkg::FORCED_SLEEP_BIT];
  assign sleep_now = (pstate == fgcc_pkg::FGCC_ACTIVE) && idle_cond &&
                     (sleep_cnt >= SLEEP_CYC - 33'h000000001);
  assign wake_now  = (pstate == fgcc_pkg::FGCC_SHUTDOWN) &&
                     ((pin_sd & th_fall) |
                      (bus_sd & bus_rise) |
                      (~pin_sd & ~bus_sd & sda_edge));

  // one counter serves every sleep source; any break restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_cnt <= 33'h000000000;
    end else if (pstate != fgcc_pkg::FGCC_ACTIVE || !idle_cond) begin
      sleep_cnt <= 33'h000000000;
    end else if (!sleep_now) begin
      sleep_cnt <= sleep_cnt + 33'h000000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate <= fgcc_pkg::FGCC_ACTIVE;
    end else begin
      case (pstate)
        fgcc_pkg::FGCC_ACTIVE:
          if (sleep_now) begin
            pstate <= fgcc_pkg::FGCC_SHUTDOWN;
          end
        fgcc_pkg::FGCC_SHUTDOWN:
          if (wake_now) begin
            pstate <= fgcc_pkg::FGCC_ACTIVE;
          end
        default: pstate <= fgcc_pkg::FGCC_ACTIVE;
      endcase
    end
  end

  assign shutdown_active = (pstate == fgcc_pkg::FGCC_SHUTDOWN);

  // ------------------------------------------------------------
  // derived controls
  // ------------------------------------------------------------
  logic meas_on;
  logic src_therm;
  assign meas_on = pri_act[fgcc_pkg::TEMP_CHAN_EN_BIT] &
                   (pri_act[fgcc_pkg::THERM_MEAS_EN_BIT] |
                    pri_act[fgcc_pkg::THERM_BIAS_BIT]);
  // without thermistor measurement the die sensor is the only valid source
  assign src_therm = pri_act[fgcc_pkg::TEMP_SRC_SEL_BIT] &
                     pri_act[fgcc_pkg::THERM_MEAS_EN_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_measure_enable       <= 1'b0;
      thermistor_bias_on        <= 1'b0;
      temperature_source_select <= 1'b0;
      temperature_in_use        <= 16'h0000;
    end else begin
      temp_measure_enable       <= meas_on;
      thermistor_bias_on        <= pri_act[fgcc_pkg::THERM_BIAS_BIT] |
                                   meas_on;
      temperature_source_select <= src_therm;
      if (pri_act[fgcc_pkg::HOST_TEMP_BIT]) begin
        temperature_in_use <= host_temperature;
      end else if (src_therm) begin
        temperature_in_use <= thermistor_temperature;
      end else begin
        temperature_in_use <= die_temperature;
      end
    end
  end

  logic [3:0] tc_field;
  logic [1:0] dr_field;
  assign tc_field = sec_act[fgcc_pkg::POWER_TC_LSB +: 4];
  assign dr_field = sec_act[fgcc_pkg::DEEP_RELAX_LSB +: 2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hypothetical_rate_enable <= 1'b0;
      peak_power_calc_enable   <= 1'b0;
      model_load_trigger       <= 1'b0;
      power_average_timeconst  <= 32'h00000000;
      deep_relax_window        <= 8'h00;
    end else begin
      hypothetical_rate_enable <= sec_act[fgcc_pkg::HYPO_RATE_EN_BIT];
      peak_power_calc_enable   <= sec_act[fgcc_pkg::PEAK_POWER_EN_BIT];
      model_load_trigger       <= sec[fgcc_pkg::MODEL_LOAD_BIT];
      power_average_timeconst  <= fgcc_pkg::POWER_TC_BASE << tc_field;
      deep_relax_window        <= fgcc_pkg::RELAX_BASE << dr_field;
    end
  end

  // constant power: i * v / ((v + ve) / 2) = i * 2v / (v + ve)
  logic signed [33:0] cp_num;
  logic signed [17:0] cp_den;
  logic signed [33:0] cp_quo;
  assign cp_num = 34'($signed(average_current) *
                      $signed({1'b0, average_cell_voltage, 1'b0}));
  assign cp_den = $signed({1'b0, 17'({1'b0, average_cell_voltage} +
                                      {1'b0, empty_voltage_setting})});
  assign cp_quo = (cp_den == 18'sh00000) ? 34'(signed'(average_current)) :
                  cp_num / 34'(cp_den);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      estimate_current <= 16'h0000;
    end else if (sec_act[fgcc_pkg::CONST_POWER_BIT]) begin
      estimate_current <= cp_quo[15:0];
    end else begin
      estimate_current <= average_current;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_reset_words : assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> pri == 16'h2210 && sec == 16'h3658)
    else $error("control words not at reset values");

  chk_apply_period : assert property (@(posedge pclk) disable iff (!presetn)
    task_tick |=> pri_act == $past(pri) && sec_act == $past(sec))
    else $error("written control not applied at task tick");

  chk_latch_hold : assert property (@(posedge pclk) disable iff (!presetn)
    latch_cls[1] && stat[1] && !(wr_stat && pwdata[1]) |=> stat[1])
    else $error("latched temperature flag lost");

  chk_auto_clear : assert property (@(posedge pclk) disable iff (!presetn)
    !latch_cls[0] && !thresh_exceeded[0] |=> !stat[0])
    else $error("unlatched soc flag did not clear");

  chk_wake_sda : assert property (@(posedge pclk) disable iff (!presetn)
    shutdown_active && !pin_sd && !bus_sd && sda_edge
      |=> !shutdown_active)
    else $error("no wake on data line edge");

  chk_forced_clear : assert property (@(posedge pclk) disable iff (!presetn)
    $fell(shutdown_active) && !$past(wr_pri)
      |-> !pri[fgcc_pkg::FORCED_SLEEP_BIT])
    else $error("forced sleep not cleared on wake");

  chk_measure_gate : assert property (@(posedge pclk) disable iff (!presetn)
    temp_measure_enable |-> $past(pri_act[9] && (pri_act[4] || pri_act[3])))
    else $error("temperature measured while disabled");

  chk_bias_force : assert property (@(posedge pclk) disable iff (!presetn)
    pri_act[fgcc_pkg::THERM_BIAS_BIT] ##1 pri_act[fgcc_pkg::THERM_BIAS_BIT]
      |-> thermistor_bias_on)
    else $error("bias switch off while forced");

  chk_insert_alert : assert property (@(posedge pclk) disable iff (!presetn)
    pri_act[1] && stat[fgcc_pkg::ST_INSERT_BIT] |=> alert_output_pin)
    else $error("insertion alert missing");

  chk_model_clear : assert property (@(posedge pclk) disable iff (!presetn)
    model_load_done && !wr_sec |=> !sec[fgcc_pkg::MODEL_LOAD_BIT])
    else $error("model load trigger not cleared");

  cov_sleep  : cover property (@(posedge pclk) disable iff (!presetn)
    sleep_now);
  cov_wake   : cover property (@(posedge pclk) disable iff (!presetn)
    wake_now);
  cov_alert  : cover property (@(posedge pclk) disable iff (!presetn)
    $rose(alert_output_pin));
  cov_constant_power_select : cover property (@(posedge pclk) disable iff (!presetn)
    sec_act[fgcc_pkg::CONST_POWER_BIT] && cp_den != 18'sh00000);

endmodule : fgcc_config_control

// File: hw/fgcc_task_timer.sv
// fgcc_task_timer: free-running internal task period tick
module fgcc_task_timer #(
  parameter logic [31:0] TASK_CYC = 32'(fgcc_pkg::TASK_PERIOD_CYC)
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // one-cycle tick at the end of each task period
  output logic      task_tick
);

  logic [31:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt       <= 32'h00000000;
      task_tick <= 1'b0;
    end else if (cnt >= TASK_CYC - 32'h00000001) begin
      cnt       <= 32'h00000000;
      task_tick <= 1'b1;
    end else begin
      cnt       <= cnt + 32'h00000001;
      task_tick <= 1'b0;
    end
  end

  chk_tick_spacing : assert property (@(posedge pclk) disable iff (!presetn)
    task_tick |=> !task_tick)
    else $error("task tick lasted more than one cycle");

endmodule : fgcc_task_timer

// File: inc/fgcc_pkg.sv
// fgcc_pkg: shared constants for the fuel gauge configuration control block
//
// Overview of operation
// - Reset loads primary control 0x2210 and secondary control 0x3658.
// - A written control bit takes effect within one internal task period.
// - Primary D15 picks die sensor or thermistor; thermistor needs measure enable.
// - Latch bits keep alert flags until cleared; otherwise flags follow threshold.
// - Pin shutdown: sense pin high past timeout sleeps; pin low wakes.
// - With both shutdown enables zero, any serial data edge wakes.
// - Temperature measured only when channel enabled and measure or bias-force set.
// - External temperature bit selects host-written temperature over own measurement.
// - Forced sleep shuts down after timeout; cleared at power-up and wake.
// - Bus idle shutdown: both lines low past timeout sleeps; rise wakes.
// - Bias-force bit keeps thermistor bias switch on permanently.
// - Threshold alert enable gates only the alert pin, not the flags.
// - Insertion and removal alert enables raise alert on sense pin events.
// - Hypothetical-rate and peak-power enables at zero stop those calculations.
// - Power time constant is 45 s times two to the (field minus 6).
// - Step alert enable routes the one-percent step flag; zero after reset.
// - Temperature alert enable permits or suppresses temperature alerts; one after reset.
// - Host sets model-load trigger; device clears it when loading completes.
// - Deep-relax field picks 0.8, 1.6, 3.2 or 6.4 hour window start.
// - Constant-power select scales current by voltage over mean with empty.
package fgcc_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint unsigned CLK_KHZ           = 100000;
  localparam longint unsigned SLEEP_TIMEOUT_MS  = 45000;
  localparam longint unsigned SLEEP_TIMEOUT_CYC = SLEEP_TIMEOUT_MS * CLK_KHZ;
  localparam longint unsigned TASK_PERIOD_MS    = 175;
  localparam longint unsigned TASK_PERIOD_CYC   = TASK_PERIOD_MS * CLK_KHZ;

  // ------------------------------------------------------------
  // register map (printed offsets are indices, byte address = 4x)
  // ------------------------------------------------------------
  localparam logic [9:0]  PRI_IDX   = 10'h01D;
  localparam logic [9:0]  SEC_IDX   = 10'h0BB;
  localparam logic [9:0]  STAT_IDX  = 10'h0F0;
  localparam logic [11:0] PRI_ADDR  = {PRI_IDX, 2'b00};
  localparam logic [11:0] SEC_ADDR  = {SEC_IDX, 2'b00};
  localparam logic [11:0] STAT_ADDR = {STAT_IDX, 2'b00};

  localparam logic [15:0] PRI_RESET  = 16'h2210;
  localparam logic [15:0] SEC_RESET  = 16'h3658;
  localparam logic [6:0]  STAT_RESET = 7'h60;

  // ------------------------------------------------------------
  // primary control word fields
  // ------------------------------------------------------------
  localparam int TEMP_SRC_SEL_BIT   = 15;
  localparam int SOC_LATCH_BIT      = 14;
  localparam int TEMP_LATCH_BIT     = 13;
  localparam int VOLT_LATCH_BIT     = 12;
  localparam int CURR_LATCH_BIT     = 11;
  localparam int PIN_SHUTDOWN_BIT   = 10;
  localparam int TEMP_CHAN_EN_BIT   = 9;
  localparam int HOST_TEMP_BIT      = 8;
  localparam int FORCED_SLEEP_BIT   = 7;
  localparam int BUS_IDLE_FORCED_SLEEP_BIT  = 6;
  localparam int THERM_MEAS_EN_BIT  = 4;
  localparam int THERM_BIAS_BIT     = 3;
  localparam int THRESH_ALERT_BIT   = 2;
  localparam int INSERT_ALERT_BIT   = 1;
  localparam int REMOVE_ALERT_BIT   = 0;

  // ------------------------------------------------------------
  // secondary control word fields
  // ------------------------------------------------------------
  localparam int HYPO_RATE_EN_BIT   = 13;
  localparam int PEAK_POWER_EN_BIT  = 12;
  localparam int POWER_TC_LSB       = 8;
  localparam int STEP_ALERT_EN_BIT  = 7;
  localparam int TEMP_ALERT_EN_BIT  = 6;
  localparam int MODEL_LOAD_BIT     = 5;
  localparam int DEEP_RELAX_LSB     = 2;
  localparam int CONST_POWER_BIT    = 1;

  // power time constant in 1/64 s: 45 s * 2^(f-6) = 45 * 2^f / 64
  localparam logic [31:0] POWER_TC_BASE = 32'h0000002D;
  // deep relax window start in tenths of an hour, doubled per step
  localparam logic [7:0]  RELAX_BASE    = 8'h08;

  // ------------------------------------------------------------
  // status flags (alert classes soc, temp, volt, curr, then events)
  // ------------------------------------------------------------
  localparam int ST_INSERT_BIT   = 4;
  localparam int ST_REMOVE_BIT   = 5;
  localparam int ST_STEP_BIT     = 6;
  localparam int ST_SHUTDOWN_BIT = 8;

  typedef enum logic [0:0] {
    FGCC_ACTIVE   = 1'b0,
    FGCC_SHUTDOWN = 1'b1
  } fgcc_power_t;

endpackage : fgcc_pkg

// File: verification/fgcc_host_pins.sv
// fgcc_host_pins: host side pin model for the gauge
module fgcc_host_pins (
  input  wire logic pclk,
  input  wire logic wake_req,
  input  wire logic cell_out,
  output logic      sda_in,
  output logic      scl_in,
  output logic      temperature_sense_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold = 2'h0;
  // a short low pulse on data; released lines show the pull-up level
  always @(posedge pclk) begin
    if (wake_req) hold <= 2'h3;
    else if (hold != 2'h0) hold <= hold - 2'h1;
  end
  assign sda_in = (hold == 2'h0);
  assign scl_in = 1'b1;
  // thermistor holds the sense pin low while a cell is fitted
  assign temperature_sense_pin = cell_out;
endmodule : fgcc_host_pins

// File: verification/test_fuel_gauge_config_control.sv
// test_fuel_gauge_config_control: apb bench for the control registers
module test_fuel_gauge_config_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] PA = fgcc_pkg::PRI_ADDR;
  localparam logic [11:0] SA = fgcc_pkg::SEC_ADDR;
  localparam logic [11:0] ST = fgcc_pkg::STAT_ADDR;
  // short sleep count stands for a host that already left hibernation
  localparam int SLP = 50;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wake_req;
  logic temperature_sense_pin, sda_in, scl_in, shutdown_active;
  logic temperature_source_select, temp_measure_enable;
  logic hypothetical_rate_enable, peak_power_calc_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, power_average_timeconst, r;
  logic [15:0] ta, tb, tc, cur, volt, vemp, m_pri, m_sec;
  logic [15:0] temperature_in_use;
  logic [7:0]  deep_relax_window;
  logic        e;
  logic        stp, mld, cell_out, alert_output_pin, thermistor_bias_on;
  logic        model_load_trigger;
  logic [3:0]  thr;
  logic [15:0] estimate_current;
  logic [15:0] exp_q[$];
  longint      q;
  int err_count = 0, cmp_count = 0, cyc = 0, seed = 32'h8187;

  fgcc_config_control #(.SLEEP_CYC(33'(SLP)), .TASK_CYC(32'h8)) DUT (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .temperature_sense_pin, .sda_in, .scl_in,
    .thresh_exceeded(thr), .charge_step_event(stp),
    .model_load_done(mld), .die_temperature(ta),
    .thermistor_temperature(tb), .host_temperature(tc),
    .average_current(cur), .average_cell_voltage(volt),
    .empty_voltage_setting(vemp), .alert_output_pin,
    .shutdown_active, .temperature_source_select, .temp_measure_enable,
    .thermistor_bias_on, .temperature_in_use, .hypothetical_rate_enable,
    .peak_power_calc_enable, .model_load_trigger,
    .power_average_timeconst, .deep_relax_window, .estimate_current);
  fgcc_host_pins pins (.pclk, .wake_req, .cell_out, .sda_in, .scl_in,
    .temperature_sense_pin);

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      err_count++;
      $display("ERROR %0t: got %h want %h", $time, s, x);
    end
  endtask : chk

  task automatic close_out();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, wake_req, stp, mld, cell_out} = 8'h0;
    thr = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    {ta, tb} = $random(seed);
    {tc, cur} = $random(seed);
    {volt, vemp} = $random(seed);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(power_average_timeconst, 32'd45 << fgcc_pkg::SEC_RESET[11:8]);
    chk(32'(deep_relax_window), 32'h20);
    apb(PA, 1'b0, 32'h0, r, e);
    chk(r, 32'h2210);
    apb(SA, 1'b0, 32'h0, r, e);
    chk(r, 32'h3658);
    apb(12'h010, 1'b0, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    repeat (6) begin
      // no forced sleep here; reserved zeros and the fixed one kept
      m_pri = 16'($random(seed)) & 16'hFF5F;
      m_sec = (16'($random(seed)) & 16'h3FFE) | 16'h0010;
      exp_q.push_back(m_pri);
      exp_q.push_back(m_sec);
      apb(PA, 1'b1, {16'h0, m_pri}, r, e);
      apb(SA, 1'b1, {16'h0, m_sec}, r, e);
      apb(PA, 1'b0, 32'h0, r, e);
      chk(r, {16'h0, exp_q.pop_front()});
      apb(SA, 1'b0, 32'h0, r, e);
      chk(r, {16'h0, exp_q.pop_front()});
      repeat (12) @(posedge pclk);
      chk(power_average_timeconst, 32'd45 << m_sec[11:8]);
      chk(32'(deep_relax_window), 32'h8 << m_sec[3:2]);
      chk(32'({hypothetical_rate_enable, peak_power_calc_enable}),
          32'(m_sec[13:12]));
      chk(32'(temp_measure_enable),
          32'(m_pri[9] & (m_pri[4] | m_pri[3])));
      chk(32'(temperature_source_select), 32'(m_pri[15] & m_pri[4]));
      chk(32'(temperature_in_use), 32'(m_pri[8] ? tc :
          (m_pri[15] & m_pri[4]) ? tb : ta));
      chk(32'(thermistor_bias_on),
          32'(m_pri[3] | (m_pri[9] & m_pri[4])));
      chk(32'(model_load_trigger), 32'(m_sec[5]));
      q = m_sec[1] ? longint'($signed(cur)) * longint'(volt) * 2 /
          (longint'(volt) + longint'(vemp)) : longint'($signed(cur));
      chk(32'(estimate_current), 32'(q[15:0]));
    end
    apb(PA, 1'b1, 32'h2290, r, e);
    repeat (SLP + 10) @(posedge pclk);
    chk(32'(shutdown_active), 32'h1);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(32'(shutdown_active), 32'h0);
    apb(PA, 1'b0, 32'h0, r, e);
    chk(r, 32'h2210);
    // temperature class latched, soc class not; threshold and insert alerts
    apb(PA, 1'b1, 32'h2216, r, e);
    apb(SA, 1'b1, {16'h0, fgcc_pkg::SEC_RESET}, r, e);
    repeat (12) @(posedge pclk);
    thr <= 4'h3;
    @(posedge pclk);
    thr <= 4'h0;
    @(posedge pclk);
    apb(ST, 1'b0, 32'h0, r, e);
    chk(r, 32'h62);
    chk(32'(alert_output_pin), 32'h1);
    apb(ST, 1'b1, 32'h7F, r, e);
    stp <= 1'b1;
    @(posedge pclk);
    stp <= 1'b0;
    apb(ST, 1'b0, 32'h0, r, e);
    chk(r, 32'h40);
    chk(32'(alert_output_pin), 32'h0);
    cell_out <= 1'b1;
    repeat (6) @(posedge pclk);
    cell_out <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'(alert_output_pin), 32'h1);
    apb(ST, 1'b0, 32'h0, r, e);
    chk(r, 32'h70);
    // model load handshake
    apb(SA, 1'b1, 32'h3678, r, e);
    repeat (2) @(posedge pclk);
    chk(32'(model_load_trigger), 32'h1);
    mld <= 1'b1;
    @(posedge pclk);
    mld <= 1'b0;
    apb(SA, 1'b0, 32'h0, r, e);
    chk(r, 32'h3658);
    chk(32'(model_load_trigger), 32'h0);
    close_out();
  end
endmodule : test_fuel_gauge_config_control
